/* design/host_decode_pkg.sv */
// Shared constants and types for the host decode block.
package host_decode_pkg;
    // Local address regions: scratchpad by full address compare, the others by local address bits 19..16.
    localparam logic [19:0] LOC_SCRATCH_TOP = 20'h01FFF;
    localparam logic [3:0] LOC_SHARED_SEG = 4'h3;
    localparam logic [3:0] LOC_LOCKED_SEG = 4'h7;
    localparam logic [3:0] LOC_ROM_SEG = 4'hF;
    // Local I/O ports, selected by local address bits 7..4.
    localparam logic [3:0] LIO_LEVEL = 4'h0;
    localparam logic [3:0] LIO_CTRL = 4'h1;
    localparam logic [3:0] LIO_VECTOR = 4'h3;
    localparam logic [3:0] LIO_CMD = 4'h4;
    localparam logic [3:0] LIO_STATUS = 4'h5;
    localparam logic [3:0] LIO_CAUSE_LEVEL = 4'h6;
    // Control port codes.
    localparam logic [7:0] CTRL_LOCK_ON = 8'h1E;
    localparam logic [7:0] CTRL_LOCK_OFF = 8'h16;
    localparam logic [7:0] CTRL_VECT_ON = 8'h1D;
    localparam logic [7:0] CTRL_VECT_OFF = 8'h15;
    // Level port fields and status bit positions.
    localparam int LEVEL_ON_BIT = 3;
    localparam int ST_LOCK_BIT = 4;
    localparam int ST_IRQ_BIT = 5;
    localparam int ST_CMD_BIT = 6;
    // Shared RAM slot time.
    localparam int CLK_PERIOD_NS = 10;
    localparam int RAM_SLOT_NS = 100;
    localparam int RAM_SLOT_CYCLES = (RAM_SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NUM_CAUSES = 4;

    typedef enum logic [1:0] {OWN_NONE, OWN_HOST, OWN_LOCAL, OWN_REFRESH} owner_type;

    // Host bus pins as seen after the synchroniser.
    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] data;
        logic memRd;
        logic memWr;
        logic ioRd;
        logic ioWr;
        logic byteHigh;
        logic lock;
        logic intAck;
    } hostPins_type;

    // Board straps and switches.
    typedef struct packed {
        logic [15:0] ioBase;
        logic [7:0] memBase;
        logic narrowIo;
        logic emulation;
    } straps_type;
endpackage

/* design/shared_ram_arbiter.sv */
// Arbiter that hands shared RAM slots to refresh, local and host requesters.
`timescale 1ns/10ps
module shared_ram_arbiter (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset_n,
    // Requests, held until done.
    input wire logic hostReq,
    input wire logic localReq,
    input wire logic refreshReq,
    // Lock holds.
    input wire logic localLock,
    input wire logic hostLock,
    // Grant.
    output host_decode_pkg::owner_type owner,
    output logic slotDone
);
    import host_decode_pkg::*;

    owner_type owner_q, owner_d;
    logic [7:0] slotCount_q;
    logic slotEnd;
    logic hostOk;
    logic localOk;

    // A slot that is already running is never cut short.
    assign slotEnd = (owner_q != OWN_NONE) && (slotCount_q == 8'(RAM_SLOT_CYCLES - 1));
    assign hostOk = hostReq && !localLock;
    assign localOk = localReq && !hostLock;

    always_comb begin
        owner_d = owner_q;
        case (owner_q)
            OWN_NONE: begin
                if (refreshReq) begin
                    owner_d = OWN_REFRESH;
                end else if (localOk) begin
                    owner_d = OWN_LOCAL;
                end else if (hostOk) begin
                    owner_d = OWN_HOST;
                end
            end
            OWN_HOST, OWN_LOCAL, OWN_REFRESH: begin
                if (slotEnd) begin
                    owner_d = OWN_NONE;
                end
            end
            default: owner_d = OWN_NONE;
        endcase
    end

    // Slot owner and length counter.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            owner_q <= OWN_NONE;
            slotCount_q <= 8'h00;
        end else begin
            owner_q <= owner_d;
            slotCount_q <= (owner_q == OWN_NONE || slotEnd) ? 8'h00 : slotCount_q + 8'h01;
        end
    end

    assign owner = owner_q;
    // Done is flagged in the last slot cycle, while the owner can still be seen.
    assign slotDone = slotEnd;
endmodule

/* design/dual_port_host_decode.sv */
// Host slave decode, shared RAM access and host interrupts of the terminal board.
// How it works
// - Host RAM cycles may be single bytes or full 16-bit words.
// - Full I/O mode compares all sixteen host I/O address lines.
// - Narrow I/O mode compares only the low eight address lines.
// - The I/O base is set per single port by switches.
// - Shared RAM sits on any 64K boundary of 16 MB.
// - Host address lines 23..16 are compared with the memory switches.
// - A host RAM cycle waits while refresh or local access runs.
// - The board is only a slave: D16, M24, I16, two-level vectored.
// - Interrupts go out vectored with a vector, or as plain levels.
// - Causes: new input, output done, line status, RAM parity error.
// - Each cause has its own programmable level and vector.
// - All eight channels share each cause's level and vector.
// - Emulation mode uses one plain level, reloaded on any channel reset.
// - Local addresses below 2000H select scratchpad RAM and local I/O.
// - Shared RAM appears unlocked at 3xxxxH and locked at 7xxxxH.
// - Local addresses Fxxxx select the program ROM.
// - Control code 1EH allows host lock, 16H disables it.
`timescale 1ns/10ps
module dual_port_host_decode (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset_n,
    // Host bus pins and board straps.
    input host_decode_pkg::hostPins_type hostPins,
    input host_decode_pkg::straps_type straps,
    output logic [15:0] hostDataOut,
    output logic hostDataOe,
    output logic hostAck,
    output logic [7:0] hostIrq,
    // Local processor side.
    input wire logic [19:0] localAddr,
    input wire logic [7:0] localDataIn,
    input wire logic localMemRd,
    input wire logic localMemWr,
    input wire logic localIoRd,
    input wire logic localIoWr,
    output logic [7:0] localDataOut,
    output logic localReady,
    output logic scratchSel,
    output logic romSel,
    output logic lockActive,
    output logic cmdReady,
    // Event sources.
    input wire logic refreshReq,
    input wire logic [3:0] causeEvent,
    input wire logic [3:0] causeClear,
    input wire logic channelReset,
    input wire logic [2:0] commonLevelIn,
    // Shared RAM port.
    input wire logic [15:0] ramRdData,
    output logic [14:0] ramAddr,
    output logic [15:0] ramWrData,
    output logic [1:0] ramByteWe
);
    import host_decode_pkg::*;

    hostPins_type pinMeta_q, pins_q, pinsPrev_q;
    straps_type strapMeta_q, strap_q;
    owner_type owner;
    logic slotDone;
    logic lockAllowed_q, vectored_q, hostBusy_q, localBusy_q;
    logic [7:0] cmd_q, manualLevel_q;
    logic [2:0] causeLevel_q [NUM_CAUSES];
    logic [7:0] causeVector_q [NUM_CAUSES];
    logic [2:0] commonLevel_q;
    logic [3:0] pending_q;

    // Pins cross into the clock domain through two flip-flops.
    always_ff @(posedge core_clk) begin
        pinMeta_q <= hostPins;
        pins_q <= pinMeta_q;
        pinsPrev_q <= pins_q;
        strapMeta_q <= straps;
        strap_q <= strapMeta_q;
    end

    wire memHit = pins_q.addr[23:16] == strap_q.memBase;
    wire ioFull = pins_q.addr[15:0] == strap_q.ioBase;
    wire ioNarrow = pins_q.addr[7:0] == strap_q.ioBase[7:0];
    wire ioHit = strap_q.narrowIo ? ioNarrow : ioFull;
    wire memStart = memHit && (pins_q.memRd || pins_q.memWr) && !hostBusy_q && !hostAck;
    wire ioStart = ioHit && (pins_q.ioRd || pins_q.ioWr) && !hostBusy_q && !hostAck;
    wire ackStart = pins_q.intAck && !pinsPrev_q.intAck && vectored_q && !strap_q.emulation;
    wire strobeGone = !(pins_q.memRd || pins_q.memWr || pins_q.ioRd || pins_q.ioWr || pins_q.intAck);

    wire locScratch = localAddr <= LOC_SCRATCH_TOP;
    wire locUnlocked = localAddr[19:16] == LOC_SHARED_SEG;
    wire locLocked = localAddr[19:16] == LOC_LOCKED_SEG;
    wire locRom = localAddr[19:16] == LOC_ROM_SEG;
    wire locShared = (locUnlocked || locLocked) && (localMemRd || localMemWr);
    wire locIoWr = localIoWr && locScratch;
    wire locIoRd = localIoRd && locScratch;
    wire [1:0] causeSel = localAddr[1:0];

    wire hostWord = pins_q.byteHigh && !pins_q.addr[0];
    wire [1:0] hostLanes = hostWord ? 2'h3 : (pins_q.addr[0] ? 2'h2 : 2'h1);
    wire [15:0] hostWrLanes = (pins_q.addr[0] && !pins_q.byteHigh) ?
        {pins_q.data[7:0], pins_q.data[7:0]} : pins_q.data;

    wire hostLockHold = pins_q.lock && lockAllowed_q && hostBusy_q;

    shared_ram_arbiter arbiter (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .hostReq(hostBusy_q),
        .localReq(localBusy_q),
        .refreshReq(refreshReq),
        .localLock(lockActive),
        .hostLock(hostLockHold),
        .owner(owner),
        .slotDone(slotDone)
    );

    // Lowest numbered pending cause answers an acknowledge.
    wire [1:0] firstCause = pending_q[0] ? 2'd0 : (pending_q[1] ? 2'd1 :
        (pending_q[2] ? 2'd2 : 2'd3));
    wire [3:0] ackClear = ackStart ? 4'(1 << firstCause) : 4'h0;

    wire [3:0] pending_d = causeEvent | (pending_q & ~causeClear & ~ackClear);

    logic [7:0] levelMap;
    always_comb begin
        levelMap = manualLevel_q;
        for (int c = 0; c < NUM_CAUSES; c++) begin
            if (pending_q[c]) begin
                levelMap[strap_q.emulation ? commonLevel_q : causeLevel_q[c]] = 1'b1;
            end
        end
    end

    // Host cycle sequencing and answer.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            hostBusy_q <= 1'b0;
            hostAck <= 1'b0;
            hostDataOut <= 16'h0000;
            hostDataOe <= 1'b0;
            cmd_q <= 8'h00;
            cmdReady <= 1'b0;
        end else begin
            if (memStart) begin
                hostBusy_q <= 1'b1;
            end else if (slotDone && owner == OWN_HOST) begin
                hostBusy_q <= 1'b0;
                hostAck <= 1'b1;
                hostDataOe <= pins_q.memRd;
                hostDataOut <= (pins_q.addr[0] && !pins_q.byteHigh) ?
                    {8'h00, ramRdData[15:8]} : ramRdData;
            end else if (ioStart) begin
                hostAck <= 1'b1;
                hostDataOe <= pins_q.ioRd;
                hostDataOut <= {8'h00, 1'b0, cmdReady, |pending_q, lockActive, 4'h0};
            end else if (ackStart) begin
                hostAck <= 1'b1;
                hostDataOe <= 1'b1;
                hostDataOut <= {8'h00, causeVector_q[firstCause]};
            end else if (strobeGone) begin
                hostAck <= 1'b0;
                hostDataOe <= 1'b0;
            end
            // A new host command wins over the local read that clears it.
            if (ioStart && pins_q.ioWr) begin
                cmd_q <= pins_q.data[7:0];
                cmdReady <= 1'b1;
            end else if (locIoRd && localAddr[7:4] == LIO_CMD) begin
                cmdReady <= 1'b0;
            end
        end
    end

    // Local programming writes and interrupt state.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            lockAllowed_q <= 1'b0;
            vectored_q <= 1'b0;
            manualLevel_q <= 8'h00;
            commonLevel_q <= 3'h0;
            pending_q <= 4'h0;
            hostIrq <= 8'h00;
            for (int c = 0; c < NUM_CAUSES; c++) begin
                causeLevel_q[c] <= 3'h0;
                causeVector_q[c] <= 8'h00;
            end
        end else begin
            pending_q <= pending_d;
            hostIrq <= levelMap;
            if (channelReset) begin
                commonLevel_q <= commonLevelIn;
            end
            if (locIoWr) begin
                case (localAddr[7:4])
                    LIO_CTRL: begin
                        if (localAddr[7:0] == CTRL_LOCK_ON) lockAllowed_q <= 1'b1;
                        if (localAddr[7:0] == CTRL_LOCK_OFF) lockAllowed_q <= 1'b0;
                        if (localAddr[7:0] == CTRL_VECT_ON) vectored_q <= 1'b1;
                        if (localAddr[7:0] == CTRL_VECT_OFF) vectored_q <= 1'b0;
                    end
                    LIO_LEVEL: begin
                        if (localAddr[LEVEL_ON_BIT]) begin
                            manualLevel_q[localAddr[2:0]] <= 1'b1;
                        end else if (!vectored_q) begin
                            manualLevel_q[localAddr[2:0]] <= 1'b0;
                        end
                    end
                    LIO_VECTOR: causeVector_q[causeSel] <= localDataIn;
                    LIO_CAUSE_LEVEL: causeLevel_q[causeSel] <= localDataIn[2:0];
                    default: ;
                endcase
            end
        end
    end

    // Local accesses, shared RAM driving and region selects.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            localBusy_q <= 1'b0;
            localReady <= 1'b0;
            localDataOut <= 8'h00;
            lockActive <= 1'b0;
            scratchSel <= 1'b0;
            romSel <= 1'b0;
            ramAddr <= 15'h0000;
            ramWrData <= 16'h0000;
            ramByteWe <= 2'h0;
        end else begin
            scratchSel <= locScratch && (localMemRd || localMemWr);
            romSel <= locRom && (localMemRd || localMemWr);
            localReady <= 1'b0;
            ramByteWe <= 2'h0;
            if (locShared && !localBusy_q && !localReady) begin
                localBusy_q <= 1'b1;
                lockActive <= locLocked;
            end else if (slotDone && owner == OWN_LOCAL) begin
                localBusy_q <= 1'b0;
                localReady <= 1'b1;
                localDataOut <= localAddr[0] ? ramRdData[15:8] : ramRdData[7:0];
            end else if (locIoRd && localAddr[7:4] == LIO_STATUS) begin
                localReady <= 1'b1;
                localDataOut <= {1'b0, cmdReady, |pending_q, lockActive, 4'h0};
            end else if (locIoRd && localAddr[7:4] == LIO_CMD) begin
                localReady <= 1'b1;
                localDataOut <= cmd_q;
            end else if (localMemRd && !locScratch && !locRom && !locShared) begin
                localReady <= 1'b1;
                localDataOut <= 8'h00;
            end
            // Address and data are presented for the granted slot.
            if (owner == OWN_HOST) begin
                ramAddr <= pins_q.addr[15:1];
                ramWrData <= hostWrLanes;
                ramByteWe <= pins_q.memWr ? hostLanes : 2'h0;
            end else if (owner == OWN_LOCAL) begin
                ramAddr <= localAddr[15:1];
                ramWrData <= {localDataIn, localDataIn};
                ramByteWe <= localMemWr ? (localAddr[0] ? 2'h2 : 2'h1) : 2'h0;
            end
        end
    end
endmodule

/* tb/dual_port_host_decode_assertions.sv */
// Concurrent checks on the ports of the host decode block.
`timescale 1ns/10ps
module dual_port_host_decode_assertions (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset_n,
    // Host side.
    input host_decode_pkg::hostPins_type hostPins,
    input host_decode_pkg::straps_type straps,
    input wire logic hostAck,
    input wire logic hostDataOe,
    // Local side.
    input wire logic [19:0] localAddr,
    input wire logic localMemRd,
    input wire logic localMemWr,
    input wire logic [7:0] localDataOut,
    input wire logic localReady,
    input wire logic scratchSel,
    input wire logic romSel
);
    import host_decode_pkg::*;
    logic memStb, ioStb, anyStb, memMiss, ioFull, ioMiss, unmapped;
    logic [3:0] seg;
    // Raw pin and local address decode used by the properties.
    assign memStb = hostPins.memRd | hostPins.memWr;
    assign ioStb = (hostPins.ioRd | hostPins.ioWr) & !memStb & !hostPins.intAck;
    assign anyStb = memStb | ioStb | hostPins.intAck;
    assign memMiss = memStb & !ioStb & (hostPins.addr[23:16] != straps.memBase);
    assign ioFull = ioStb & !straps.narrowIo & (hostPins.addr[15:0] == straps.ioBase);
    assign ioMiss = ioStb & !ioFull & (hostPins.addr[7:0] != straps.ioBase[7:0]);
    assign seg = localAddr[19:16];
    assign unmapped = (localAddr > LOC_SCRATCH_TOP) & (seg != LOC_SHARED_SEG)
        & (seg != LOC_LOCKED_SEG) & (seg != LOC_ROM_SEG);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // Strobe patterns held long enough to cross the pin synchronisers.
    sequence memMissHeld; (memMiss && !hostAck) [*4]; endsequence
    sequence ioMissHeld; (ioMiss && !hostAck) [*4]; endsequence
    sequence ioFullHeld; (ioFull && !hostAck) [*3]; endsequence
    AST_ACK_CAUSE: assert property ($rose(hostAck) |-> anyStb && $past(anyStb, 2))
        else $error("acknowledge without a held host strobe");
    AST_ACK_STANDS: assert property (hostAck && anyStb |=> hostAck)
        else $error("acknowledge dropped while strobes still held");
    AST_MEM_MISS: assert property (memMissHeld |-> !hostAck)
        else $error("memory cycle outside the window acknowledged");
    AST_IO_MISS: assert property (ioMissHeld |-> !hostAck)
        else $error("port cycle at a foreign address acknowledged");
    AST_IO_FULL: assert property (ioFullHeld |-> ##[1:6] hostAck)
        else $error("port cycle at the base address not acknowledged");
    AST_SCRATCH: assert property ($past(reset_n) |->
        scratchSel == ($past(localAddr) <= LOC_SCRATCH_TOP && $past(localMemRd || localMemWr)))
        else $error("scratch select does not follow the address");
    AST_ROM: assert property ($past(reset_n) |->
        romSel == ($past(localAddr[19:16]) == LOC_ROM_SEG
        && $past(localMemRd || localMemWr)))
        else $error("program memory select does not follow the address");
    AST_OE_WRITE: assert property (hostAck && (hostPins.memWr || hostPins.ioWr) |-> !hostDataOe)
        else $error("host data bus driven during a write cycle");
    AST_UNMAPPED: assert property ($rose(localMemRd) && unmapped |->
        ##[1:2] (localReady && localDataOut == 8'h00))
        else $error("unmapped local read not answered with zero");
endmodule
bind dual_port_host_decode dual_port_host_decode_assertions checks (.core_clk, .reset_n,
    .hostPins, .straps, .hostAck, .hostDataOe, .localAddr, .localMemRd, .localMemWr,
    .localDataOut, .localReady,
    .scratchSel, .romSel);

/* tb/host_bus_master.sv */
// Behavioural host bus master driving the board's host pins.
`timescale 1ns/10ps
module host_bus_master (
    // Clock.
    input wire logic core_clk,
    // Board answers.
    input wire logic hostAck,
    input wire logic [15:0] hostDataOut,
    // Host pins.
    output host_decode_pkg::hostPins_type hostPins
);
    import host_decode_pkg::*;
    // Pins start idle with every strobe low.
    initial hostPins = '0;
    // Kind 0 memory read, 1 memory write, 2 port read, 3 port write, 4 interrupt acknowledge.
    // word cycles keep 16-bit values whole
    task automatic xfer(input int kind, input logic [23:0] a, input logic [15:0] d,
        input logic bh, input int limit, output logic [15:0] rd, output logic ok);
        int n;
        @(negedge core_clk);
        hostPins.addr = a;
        hostPins.data = d;
        hostPins.byteHigh = bh;
        {hostPins.memRd, hostPins.memWr, hostPins.ioRd, hostPins.ioWr, hostPins.intAck} = 5'h10 >> kind;
        ok = 1'b0;
        for (n = 0; n < limit && !ok; n++) begin
            @(posedge core_clk);
            ok = (hostAck === 1'b1);
        end
        rd = hostDataOut;
        // Released lines show the inverse of their last value, not a held copy.
        @(negedge core_clk);
        {hostPins.memRd, hostPins.memWr, hostPins.ioRd, hostPins.ioWr, hostPins.intAck} = 5'h00;
        hostPins.addr = ~a;
        hostPins.data = ~d;
        for (n = 0; n < 20 && hostAck !== 1'b0; n++) @(negedge core_clk);
    endtask
endmodule

/* tb/dual_port_host_decode_tb.sv */
// Self-checking bench with host model, shared RAM model and byte-level expectation.
`timescale 1ns/10ps
module dual_port_host_decode_tb;
    import host_decode_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    hostPins_type hostPins;
    straps_type straps;
    logic [15:0] hostDataOut, ramRdData, ramWrData, rd, off;
    logic hostDataOe, hostAck, localReady, scratchSel, romSel, lockActive, cmdReady, ok, rdy;
    logic [7:0] hostIrq, localDataIn, localDataOut, lrd, vec;
    logic [19:0] localAddr;
    logic localMemRd, localMemWr, localIoRd, localIoWr, refreshReq, channelReset;
    logic [3:0] causeEvent, causeClear;
    logic [2:0] commonLevelIn;
    logic [14:0] ramAddr;
    logic [1:0] ramByteWe;
    logic [15:0] ramMem [0:32767];
    logic [7:0] expMem [int];
    logic [19:0] regions [5] = '{20'h01FFF, 20'h02000, 20'hF0000, 20'hEFFFF, 20'hFFFFF};
    int miscompares = 0;
    int totalChecks = 0;

    // Clock at 100 MHz.
    always #5 core_clk = ~core_clk;

    dual_port_host_decode dut (.core_clk, .reset_n, .hostPins, .straps, .hostDataOut,
        .hostDataOe, .hostAck, .hostIrq, .localAddr, .localDataIn, .localMemRd, .localMemWr,
        .localIoRd, .localIoWr, .localDataOut, .localReady, .scratchSel, .romSel, .lockActive,
        .cmdReady, .refreshReq, .causeEvent, .causeClear, .channelReset, .commonLevelIn,
        .ramRdData, .ramAddr, .ramWrData, .ramByteWe);
    host_bus_master host (.core_clk, .hostAck, .hostDataOut, .hostPins);

    // Shared RAM: combinational read, byte-lane writes on the rising edge.
    assign ramRdData = ramMem[ramAddr];
    always @(posedge core_clk) begin
        if (ramByteWe[0]) ramMem[ramAddr][7:0] <= ramWrData[7:0];
        if (ramByteWe[1]) ramMem[ramAddr][15:8] <= ramWrData[15:8];
    end

    // Counts a comparison and reports a difference at once.
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        totalChecks++;
        if (seen !== want) begin
            miscompares++;
            $display("ERROR %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic report_and_stop;
        if (miscompares == 0 && totalChecks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Local cycle: 0 memory read, 1 memory write, 2 port read, 3 one-cycle port write.
    task automatic localAcc(input int kind, input logic [19:0] a, input logic [7:0] d);
        @(negedge core_clk);
        localAddr = a;
        localDataIn = d;
        {localMemRd, localMemWr, localIoRd, localIoWr} = 4'b1000 >> kind;
        rdy = 1'b0;
        for (int n = 0; n < 60 && kind != 3 && !rdy; n++) begin
            @(posedge core_clk);
            rdy = (localReady === 1'b1);
        end
        lrd = localDataOut;
        @(negedge core_clk);
        {localMemRd, localMemWr, localIoRd, localIoWr} = 4'h0;
        localAddr = ~a;
    endtask

    // Host memory cycle in the shared window, checked against the byte model.
    task automatic hostMem(input logic wr, input logic [15:0] o, input logic bh);
        logic [15:0] d;
        d = 16'($urandom);
        host.xfer(int'(wr), {straps.memBase, o}, d, bh, 200, rd, ok);
        chk(16'(ok), 16'h0001);
        if (wr) begin
            expMem[o] = d[7:0];
            if (bh) expMem[o + 16'h0001] = d[15:8];
        end else if (bh) chk(rd, {expMem[o + 16'h0001], expMem[o]});
        else chk({8'h00, rd[7:0]}, {8'h00, expMem[o]});
    endtask

    // Main sequence.
    initial begin
        void'($urandom(88));
        straps = '0;
        straps.ioBase = 16'($urandom);
        straps.memBase = 8'($urandom);
        {localAddr, localDataIn, localMemRd, localMemWr, localIoRd, localIoWr} = '0;
        {refreshReq, channelReset, causeEvent, causeClear, commonLevelIn} = '0;
        repeat (12) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge core_clk);
        // Word and both byte lanes, with refresh competing for the first slot.
        off = 16'($urandom) & 16'hFFFC;
        refreshReq = 1'b1;
        fork
            hostMem(1, off, 1);
            repeat (15) @(negedge core_clk);
        join_any
        refreshReq = 1'b0;
        wait fork;
        hostMem(1, off + 16'h0002, 0);
        hostMem(1, off + 16'h0003, 0);
        hostMem(0, off, 1);
        hostMem(0, off + 16'h0002, 1);
        hostMem(0, off + 16'h0003, 0);
        for (int i = 0; i < 8; i++) begin
            host.xfer(0, {straps.memBase ^ (8'h01 << i), off}, 16'h0000, 1, 30, rd, ok);
            chk(16'(ok), 16'h0000);
        end
        foreach (regions[i]) begin
            localAddr = regions[i];
            localMemRd = 1'b1;
            repeat (2) @(negedge core_clk);
            chk(16'(scratchSel), 16'(regions[i] <= LOC_SCRATCH_TOP));
            chk(16'(romSel), 16'(regions[i][19:16] == LOC_ROM_SEG));
        end
        localMemRd = 1'b0;
        localAcc(0, {4'h5, 16'($urandom)}, 8'h00);
        chk({7'h00, rdy, lrd}, 16'h0100);
        // Local write in the plain window, locked read-back, host held off by the lock.
        vec = 8'($urandom);
        localAcc(1, {4'h3, off}, vec);
        expMem[off] = vec;
        hostMem(0, off, 0);
        localAcc(3, {12'h000, CTRL_LOCK_ON}, 8'h00);
        localAcc(0, {4'h7, off}, 8'h00);
        chk({rdy, 7'h00, lrd}, {1'b1, 7'h00, vec});
        chk(16'(lockActive), 16'h0001);
        fork
            hostMem(0, off, 0);
            begin
                repeat (40) @(negedge core_clk);
                chk(16'(hostAck), 16'h0000);
                localAcc(0, {4'h3, off}, 8'h00);
            end
        join
        chk(16'(lockActive), 16'h0000);
        localAcc(3, {12'h000, CTRL_LOCK_OFF}, 8'h00);
        // Host command, status flags, local read-back.
        host.xfer(3, {8'h00, straps.ioBase}, {8'h00, vec}, 0, 30, rd, ok);
        host.xfer(2, {8'h00, straps.ioBase}, 16'h0000, 0, 30, rd, ok);
        chk({ok, 7'h00, rd[7:0] & 8'h70}, 16'h8040);
        localAcc(2, {12'h000, LIO_CMD, 4'h0}, 8'h00);
        chk({7'h00, cmdReady, lrd}, {8'h00, vec});
        for (int i = 0; i < 16; i++) begin
            host.xfer(2, {8'h00, straps.ioBase ^ (16'h0001 << i)}, 16'h0000, 0, 12, rd, ok);
            chk(16'(ok), 16'h0000);
        end
        straps.narrowIo = 1'b1;
        repeat (4) @(negedge core_clk);
        host.xfer(2, {8'h00, ~straps.ioBase[15:8], straps.ioBase[7:0]}, 16'h0000, 0, 30, rd, ok);
        chk(16'(ok), 16'h0001);
        // Plain level line, then each cause with its own level and vector.
        localAcc(3, {12'h000, CTRL_VECT_OFF}, 8'h00);
        localAcc(3, 20'h0000B, 8'h00);
        repeat (3) @(negedge core_clk);
        chk({8'h00, hostIrq}, 16'h0008);
        localAcc(3, 20'h00003, 8'h00);
        localAcc(3, {12'h000, CTRL_VECT_ON}, 8'h00);
        for (int c = 0; c < NUM_CAUSES; c++) begin
            vec = 8'($urandom);
            localAcc(3, {12'h000, LIO_CAUSE_LEVEL, 4'(c)}, 8'(c + 4));
            localAcc(3, {12'h000, LIO_VECTOR, 4'(c)}, vec);
            causeEvent = 4'h1 << c;
            @(negedge core_clk);
            causeEvent = 4'h0;
            repeat (3) @(negedge core_clk);
            chk({8'h00, hostIrq}, 16'h0010 << c);
            host.xfer(4, 24'h000000, 16'h0000, 0, 30, rd, ok);
            chk({7'h00, ok, rd[7:0]}, {8'h01, vec});
            chk({8'h00, hostIrq}, 16'h0000);
        end
        // Emulation: cause 2 goes to the level loaded at a channel reset.
        straps.emulation = 1'b1;
        commonLevelIn = 3'($urandom);
        channelReset = 1'b1;
        @(negedge core_clk);
        channelReset = 1'b0;
        repeat (3) @(negedge core_clk);
        // Event and clear in one cycle: the event wins, a later clear removes it.
        causeEvent = 4'h4;
        causeClear = 4'h4;
        @(negedge core_clk);
        causeEvent = 4'h0;
        causeClear = 4'h0;
        repeat (4) @(negedge core_clk);
        chk({8'h00, hostIrq}, 16'h0001 << commonLevelIn);
        causeClear = 4'h4;
        @(negedge core_clk);
        causeClear = 4'h0;
        repeat (3) @(negedge core_clk);
        chk({8'h00, hostIrq}, 16'h0000);
        report_and_stop();
    end

    // Watchdog: the sequence needs under 1000 cycles, so 20000 means a hang.
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        report_and_stop();
    end
endmodule
